// ### common/hrl_consts.svh
// constants of the hop radio link controller: offsets, fields, resets, rates
// assumes inclusion by bare name from package and design files
`ifndef HRL_CONSTS_SVH
`define HRL_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define HRL_OFF_CTRL      8'h00
`define HRL_OFF_OWN_ID    8'h04
`define HRL_OFF_PEER_ID   8'h08
`define HRL_OFF_NET_ID    8'h0C
`define HRL_OFF_MASK      8'h10
`define HRL_OFF_HOP_LEN   8'h14
`define HRL_OFF_FILL      8'h18
`define HRL_OFF_IDLE      8'h1C
`define HRL_OFF_REPEAT    8'h20
`define HRL_OFF_MISSED    8'h24
`define HRL_OFF_SLOTS     8'h28
`define HRL_OFF_BAUD      8'h2C
`define HRL_OFF_STATUS    8'h30

// ****************************************************************
// control field positions
// ****************************************************************
`define HRL_CTRL_MASTER   0
`define HRL_CTRL_MULTI    1
`define HRL_CTRL_ACK      2
`define HRL_CTRL_FACTORY  3

// ****************************************************************
// reset values (factory defaults)
// ****************************************************************
`define HRL_RST_MASTER    1'b0
`define HRL_RST_MULTI     1'b0
`define HRL_RST_ACK       1'b0
`define HRL_RST_ID        8'h01
`define HRL_RST_NET       16'h0000
`define HRL_RST_MASK      16'hFFFF
`define HRL_RST_HOP       8'h10
`define HRL_RST_FILL      16'h0001
`define HRL_RST_IDLE      8'h04
`define HRL_RST_REPEAT    4'h0
`define HRL_RST_MISSED    8'h08
`define HRL_RST_SLOT      8'h20
`define HRL_BCAST_ID      8'hFF

// ****************************************************************
// rates
// ****************************************************************
`define HRL_CLK_HZ        200000000
`define HRL_USER_BAUD     115200
`define HRL_DIAG_BAUD     57600

`endif

// ### common/hrl_pkg.sv
// types of the hop radio link controller
// assumes hrl_consts.svh on the include path
`include "hrl_consts.svh"

package hrl_pkg;

  typedef enum logic [1:0] {
    HRL_LINK_SEARCH = 2'b01,
    HRL_LINK_UP     = 2'b10
  } hrl_link_type;

  typedef struct packed {
    logic        broadcast;
    logic [7:0]  dest;
    logic [7:0]  src;
    logic [15:0] net;
    logic [7:0]  hop_len;
    logic [3:0]  seq;
    logic        ack_req;
    logic [7:0]  m_slot;
    logic [7:0]  s_slot;
  } hrl_hdr_type;

  typedef struct packed {
    logic        master;
    logic        multi;
    logic        ack_enable;
    logic [7:0]  own_node_id;
    logic [7:0]  peer_node_id;
    logic [15:0] net_id;
    logic [15:0] addr_match_mask;
    logic [7:0]  hop_list_len;
    logic [15:0] tx_fill_level;
    logic [7:0]  idle_frame_limit;
    logic [3:0]  repeat_count;
    logic [7:0]  missed_frame_limit;
    logic [7:0]  master_slot_size;
    logic [7:0]  slave_slot_size;
    logic [15:0] baud_div;
  } hrl_cfg_type;

  typedef struct packed {
    hrl_cfg_type  cfg;
    hrl_link_type link;
    logic [7:0]   missed;
    logic [7:0]   idle;
    logic         last_for_me;
    logic         holding;
    logic [3:0]   seq;
    logic [3:0]   rep_left;
    logic         tx_valid;
    logic         tx_repeat;
    logic         tx_take;
    hrl_hdr_type  tx_hdr;
    logic         rx_accept;
    logic [3:0]   rx_last_seq;
    logic         rx_seq_valid;
    logic         out_valid;
    logic [7:0]   out_byte;
    logic         ack_send;
    logic [7:0]   ack_dest;
    logic [7:0]   lock_m_slot;
    logic [7:0]   lock_s_slot;
    logic [15:0]  user_cnt;
    logic [15:0]  diag_cnt;
    logic         user_tick;
    logic         diag_tick;
    logic [31:0]  prdata;
    logic         pslverr;
  } hrl_state_type;

endpackage

// ### design/hrl_link_ctrl.sv
// hop radio node link and packet control with apb configuration port
// assumes one clock pclk, frame and slot pulses from the hop timer,
// received headers from the modem and buffer fill from the user port
//
// Notes on behaviour
// - good broadcast payload goes to user port
// - addressed payload delivered only by matching node
// - pair topology sends only addressed packets
// - each pair node keeps own ack setting
// - pair master launches only with link up
// - pair master addresses its one slave
// - pair master ignores fill and idle limits
// - slave launch needs link, fill or idle
// - slave launch needs last master packet ours
// - slave sends once plus repeats; pair zero
// - missed frames at limit drop to search
// - pair slave links only on addressed packets
// - ids, net, mask, hop list must match; multi-drop master skips sender id
// - slave slot sizes own until locked
// - multi-drop master sends broadcast only
// - multi-drop slave addresses master only
// - multi-drop master packets unacked; other acks optional
// - multi-drop master launches on one byte
// - multi-drop master sends once plus repeats
// - repeat copies discarded, payload not forwarded
// - user baud defaults, diagnostics baud fixed
// - factory defaults give slave, ack off
// - sending multi-drop slave continues until empty or lost
`timescale 1ns/1ps
`default_nettype none
`include "hrl_consts.svh"

module hrl_link_ctrl
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            frame_tick,
  input  wire logic            tx_slot,
  input  wire logic [15:0]     buf_count,
  input  wire logic            rx_hdr_valid,
  input  wire logic            rx_ok,
  input  wire hrl_pkg::hrl_hdr_type rx_hdr,
  input  wire logic            rx_byte_valid,
  input  wire logic [7:0]      rx_byte,
  output logic                 tx_valid,
  output logic                 tx_repeat,
  output logic                 tx_take,
  output hrl_pkg::hrl_hdr_type tx_hdr,
  output logic                 user_out_valid,
  output logic      [7:0]      user_out_byte,
  output logic                 ack_send,
  output logic      [7:0]      ack_dest,
  output logic                 link_up,
  output logic      [7:0]      master_slot_eff,
  output logic      [7:0]      slave_slot_eff,
  output logic                 user_baud_tick,
  output logic                 diag_baud_tick
);

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam logic [15:0] USER_DIV_RST =
    16'(`HRL_CLK_HZ / `HRL_USER_BAUD);
  localparam logic [15:0] DIAG_DIV =
    16'(`HRL_CLK_HZ / `HRL_DIAG_BAUD);

  hrl_pkg::hrl_state_type s_q;
  hrl_pkg::hrl_state_type s_d;
  hrl_pkg::hrl_cfg_type   cfg_rst;

  // ****************************************************************
  // factory defaults
  // ****************************************************************
  always_comb
  begin
    cfg_rst                    = '0;
    cfg_rst.master             = `HRL_RST_MASTER;
    cfg_rst.multi              = `HRL_RST_MULTI;
    cfg_rst.ack_enable         = `HRL_RST_ACK;
    cfg_rst.own_node_id        = `HRL_RST_ID;
    cfg_rst.peer_node_id       = `HRL_RST_ID;
    cfg_rst.net_id             = `HRL_RST_NET;
    cfg_rst.addr_match_mask    = `HRL_RST_MASK;
    cfg_rst.hop_list_len       = `HRL_RST_HOP;
    cfg_rst.tx_fill_level      = `HRL_RST_FILL;
    cfg_rst.idle_frame_limit   = `HRL_RST_IDLE;
    cfg_rst.repeat_count       = `HRL_RST_REPEAT;
    cfg_rst.missed_frame_limit = `HRL_RST_MISSED;
    cfg_rst.master_slot_size   = `HRL_RST_SLOT;
    cfg_rst.slave_slot_size    = `HRL_RST_SLOT;
    cfg_rst.baud_div           = USER_DIV_RST;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  logic        wr_en;
  logic        rd_en;
  logic        net_ok;
  logic        from_peer;
  logic        to_me;
  logic        for_me;
  logic        heard;
  logic        link_ok;
  logic        dup;
  logic        launch_ok;
  logic        launch;
  logic        is_up;
  logic [3:0]  rep_eff;
  logic [31:0] rd_val;
  logic        rd_err;

  always_comb
  begin
    s_d          = s_q;
    wr_en        = psel & penable & pwrite;
    rd_en        = psel & ~penable & ~pwrite;
    is_up        = s_q.link == hrl_pkg::HRL_LINK_UP;
    s_d.tx_valid = 1'b0;
    s_d.tx_take  = 1'b0;
    s_d.out_valid = 1'b0;
    s_d.ack_send = 1'b0;

    // peer filter on network, mask, hop list and sender
    net_ok = ((rx_hdr.net ^ s_q.cfg.net_id) & s_q.cfg.addr_match_mask)
             == 16'h0000 && rx_hdr.hop_len == s_q.cfg.hop_list_len;
    from_peer = net_ok && ((s_q.cfg.master && s_q.cfg.multi)
                || rx_hdr.src == s_q.cfg.peer_node_id);
    to_me  = ~rx_hdr.broadcast && rx_hdr.dest == s_q.cfg.own_node_id;
    for_me = rx_hdr.broadcast | to_me;
    heard  = rx_hdr_valid & rx_ok & from_peer;
    dup    = s_q.rx_seq_valid && rx_hdr.seq == s_q.rx_last_seq;

    // link may come up on this packet
    if (!s_q.cfg.multi)
      link_ok = to_me;
    else
      link_ok = for_me;

    // receive: delivery decision held over the payload bytes
    if (rx_hdr_valid)
    begin
      s_d.rx_accept = heard & for_me & ~dup;
      if (heard && for_me)
      begin
        s_d.rx_last_seq  = rx_hdr.seq;
        s_d.rx_seq_valid = 1'b1;
      end
    end
    if (rx_byte_valid && s_q.rx_accept)
    begin
      s_d.out_valid = 1'b1;
      s_d.out_byte  = rx_byte;
    end

    // acknowledge on the receiver side when the sender asks
    if (heard && to_me && rx_hdr.ack_req)
    begin
      s_d.ack_send = 1'b1;
      s_d.ack_dest = rx_hdr.src;
    end

    // link supervision
    if (heard)
    begin
      s_d.missed = 8'h00;
      if (!s_q.cfg.master)
        s_d.last_for_me = for_me;
      if (link_ok)
      begin
        s_d.link = hrl_pkg::HRL_LINK_UP;
        if (!s_q.cfg.master)
        begin
          s_d.lock_m_slot = rx_hdr.m_slot;
          s_d.lock_s_slot = rx_hdr.s_slot;
        end
      end
    end
    else if (frame_tick && is_up)
    begin
      if (s_q.missed + 8'h01 >= s_q.cfg.missed_frame_limit)
      begin
        s_d.link    = hrl_pkg::HRL_LINK_SEARCH;
        s_d.missed  = 8'h00;
        s_d.holding = 1'b0;
      end
      else
        s_d.missed = s_q.missed + 8'h01;
    end
    if (frame_tick && s_q.idle != 8'hFF)
      s_d.idle = s_q.idle + 8'h01;

    // launch decision per role and topology
    unique case ({s_q.cfg.master, s_q.cfg.multi})
      2'b10: launch_ok = is_up && buf_count != 16'h0000;
      2'b11: launch_ok = buf_count != 16'h0000;
      default: launch_ok = is_up && s_q.last_for_me
               && buf_count != 16'h0000
               && (s_q.holding || buf_count >= s_q.cfg.tx_fill_level
                   || s_q.idle > s_q.cfg.idle_frame_limit);
    endcase
    rep_eff = s_q.cfg.multi ? s_q.cfg.repeat_count : 4'h0;
    launch  = tx_slot && s_q.rep_left == 4'h0 && launch_ok;

    if (!s_q.cfg.master && buf_count == 16'h0000)
      s_d.holding = 1'b0;

    if (launch)
    begin
      s_d.tx_valid  = 1'b1;
      s_d.tx_repeat = 1'b0;
      s_d.tx_take   = 1'b1;
      s_d.rep_left  = rep_eff;
      s_d.seq       = s_q.seq + 4'h1;
      s_d.idle      = 8'h00;
      s_d.holding   = ~s_q.cfg.master & s_q.cfg.multi;
      s_d.tx_hdr.broadcast = s_q.cfg.master & s_q.cfg.multi;
      s_d.tx_hdr.dest = (s_q.cfg.master & s_q.cfg.multi) ? `HRL_BCAST_ID
                        : s_q.cfg.peer_node_id;
      s_d.tx_hdr.src     = s_q.cfg.own_node_id;
      s_d.tx_hdr.net     = s_q.cfg.net_id;
      s_d.tx_hdr.hop_len = s_q.cfg.hop_list_len;
      s_d.tx_hdr.seq     = s_q.seq + 4'h1;
      s_d.tx_hdr.ack_req = ~(s_q.cfg.master & s_q.cfg.multi)
                           & s_q.cfg.ack_enable;
      s_d.tx_hdr.m_slot  = s_q.cfg.master_slot_size;
      s_d.tx_hdr.s_slot  = s_q.cfg.slave_slot_size;
    end
    else if (tx_slot && s_q.rep_left != 4'h0)
    begin
      s_d.tx_valid  = 1'b1;
      s_d.tx_repeat = 1'b1;
      s_d.rep_left  = s_q.rep_left - 4'h1;
    end

    // baud enables: user divisor programmable, diagnostics fixed
    s_d.user_tick = 1'b0;
    s_d.diag_tick = 1'b0;
    if (s_q.user_cnt + 16'h0001 >= s_q.cfg.baud_div)
    begin
      s_d.user_cnt  = 16'h0000;
      s_d.user_tick = 1'b1;
    end
    else
      s_d.user_cnt = s_q.user_cnt + 16'h0001;
    if (s_q.diag_cnt + 16'h0001 >= DIAG_DIV)
    begin
      s_d.diag_cnt  = 16'h0000;
      s_d.diag_tick = 1'b1;
    end
    else
      s_d.diag_cnt = s_q.diag_cnt + 16'h0001;

    // apb read mux, captured in the setup cycle
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr)
      `HRL_OFF_CTRL:    rd_val = {29'h0, s_q.cfg.ack_enable,
                                  s_q.cfg.multi, s_q.cfg.master};
      `HRL_OFF_OWN_ID:  rd_val = {24'h0, s_q.cfg.own_node_id};
      `HRL_OFF_PEER_ID: rd_val = {24'h0, s_q.cfg.peer_node_id};
      `HRL_OFF_NET_ID:  rd_val = {16'h0, s_q.cfg.net_id};
      `HRL_OFF_MASK:    rd_val = {16'h0, s_q.cfg.addr_match_mask};
      `HRL_OFF_HOP_LEN: rd_val = {24'h0, s_q.cfg.hop_list_len};
      `HRL_OFF_FILL:    rd_val = {16'h0, s_q.cfg.tx_fill_level};
      `HRL_OFF_IDLE:    rd_val = {24'h0, s_q.cfg.idle_frame_limit};
      `HRL_OFF_REPEAT:  rd_val = {28'h0, s_q.cfg.repeat_count};
      `HRL_OFF_MISSED:  rd_val = {24'h0, s_q.cfg.missed_frame_limit};
      `HRL_OFF_SLOTS:   rd_val = {16'h0, s_q.cfg.slave_slot_size,
                                  s_q.cfg.master_slot_size};
      `HRL_OFF_BAUD:    rd_val = {16'h0, s_q.cfg.baud_div};
      `HRL_OFF_STATUS:  rd_val = {master_slot_eff, slave_slot_eff,
                                  s_q.missed, s_q.seq, s_q.rep_left[1:0],
                                  s_q.holding, is_up};
      default:          rd_err = 1'b1;
    endcase
    if (psel && !penable)
    begin
      s_d.prdata  = rd_en ? rd_val : 32'h0000_0000;
      s_d.pslverr = rd_err;
    end

    // apb writes take effect in the access cycle
    if (wr_en && !rd_err)
    begin
      unique case (paddr)
        `HRL_OFF_CTRL:
        begin
          if (pwdata[`HRL_CTRL_FACTORY])
            s_d.cfg = cfg_rst;
          else
          begin
            s_d.cfg.master     = pwdata[`HRL_CTRL_MASTER];
            s_d.cfg.multi      = pwdata[`HRL_CTRL_MULTI];
            s_d.cfg.ack_enable = pwdata[`HRL_CTRL_ACK];
          end
        end
        `HRL_OFF_OWN_ID:  s_d.cfg.own_node_id = pwdata[7:0];
        `HRL_OFF_PEER_ID: s_d.cfg.peer_node_id = pwdata[7:0];
        `HRL_OFF_NET_ID:  s_d.cfg.net_id = pwdata[15:0];
        `HRL_OFF_MASK:    s_d.cfg.addr_match_mask = pwdata[15:0];
        `HRL_OFF_HOP_LEN: s_d.cfg.hop_list_len = pwdata[7:0];
        `HRL_OFF_FILL:    s_d.cfg.tx_fill_level = pwdata[15:0];
        `HRL_OFF_IDLE:    s_d.cfg.idle_frame_limit = pwdata[7:0];
        `HRL_OFF_REPEAT:  s_d.cfg.repeat_count = pwdata[3:0];
        `HRL_OFF_MISSED:  s_d.cfg.missed_frame_limit = pwdata[7:0];
        `HRL_OFF_SLOTS:
        begin
          s_d.cfg.master_slot_size = pwdata[7:0];
          s_d.cfg.slave_slot_size  = pwdata[15:8];
        end
        `HRL_OFF_BAUD:    s_d.cfg.baud_div = pwdata[15:0];
        default:          s_d.cfg = s_d.cfg;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q                        <= '0;
      s_q.link                   <= hrl_pkg::HRL_LINK_SEARCH;
      s_q.cfg.master             <= `HRL_RST_MASTER;
      s_q.cfg.multi              <= `HRL_RST_MULTI;
      s_q.cfg.ack_enable         <= `HRL_RST_ACK;
      s_q.cfg.own_node_id        <= `HRL_RST_ID;
      s_q.cfg.peer_node_id       <= `HRL_RST_ID;
      s_q.cfg.net_id             <= `HRL_RST_NET;
      s_q.cfg.addr_match_mask    <= `HRL_RST_MASK;
      s_q.cfg.hop_list_len       <= `HRL_RST_HOP;
      s_q.cfg.tx_fill_level      <= `HRL_RST_FILL;
      s_q.cfg.idle_frame_limit   <= `HRL_RST_IDLE;
      s_q.cfg.repeat_count       <= `HRL_RST_REPEAT;
      s_q.cfg.missed_frame_limit <= `HRL_RST_MISSED;
      s_q.cfg.master_slot_size   <= `HRL_RST_SLOT;
      s_q.cfg.slave_slot_size    <= `HRL_RST_SLOT;
      s_q.cfg.baud_div           <= USER_DIV_RST;
    end
    else
      s_q <= s_d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata         = s_q.prdata;
  assign pready         = 1'b1;
  assign pslverr        = psel & penable & s_q.pslverr;
  assign tx_valid       = s_q.tx_valid;
  assign tx_repeat      = s_q.tx_repeat;
  assign tx_take        = s_q.tx_take;
  assign tx_hdr         = s_q.tx_hdr;
  assign user_out_valid = s_q.out_valid;
  assign user_out_byte  = s_q.out_byte;
  assign ack_send       = s_q.ack_send;
  assign ack_dest       = s_q.ack_dest;
  assign link_up        = s_q.link == hrl_pkg::HRL_LINK_UP;
  // locked slave follows the master's slot sizes
  assign master_slot_eff = (!s_q.cfg.master && link_up)
                           ? s_q.lock_m_slot
                           : s_q.cfg.master_slot_size;
  assign slave_slot_eff  = (!s_q.cfg.master && link_up)
                           ? s_q.lock_s_slot
                           : s_q.cfg.slave_slot_size;
  assign user_baud_tick = s_q.user_tick;
  assign diag_baud_tick = s_q.diag_tick;

endmodule
`default_nettype wire

// ### tb/hrl_link_ctrl_properties.sv
// concurrent checks on the ports of the hop radio link controller
// assumes one clock pclk and asynchronous active-low presetn
`timescale 1ns/1ps
`default_nettype none

module hrl_link_props
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 tx_slot,
  input wire logic                 rx_hdr_valid,
  input wire logic                 rx_ok,
  input wire logic                 rx_byte_valid,
  input wire logic [7:0]           rx_byte,
  input wire logic                 tx_valid,
  input wire logic                 tx_repeat,
  input wire logic                 tx_take,
  input wire hrl_pkg::hrl_hdr_type tx_hdr,
  input wire logic                 user_out_valid,
  input wire logic [7:0]           user_out_byte,
  input wire logic                 ack_send,
  input wire logic                 link_up
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // transmit side
  // ****************************************************************
  chk_tx_slot: assert property (tx_valid |-> $past(tx_slot))
    else $error("packet sent outside a transmit slot");
  chk_tx_once: assert property (tx_valid && !tx_slot |=> !tx_valid)
    else $error("packet pulse longer than one cycle");
  chk_take_orig: assert property (tx_take |-> tx_valid && !tx_repeat)
    else $error("payload pulled on a repeat copy");
  chk_rep_hdr: assert property (tx_valid && tx_repeat |-> $stable(tx_hdr))
    else $error("repeat copy header differs from original");

  // ****************************************************************
  // receive side
  // ****************************************************************
  chk_out_byte: assert property (user_out_valid |->
    $past(rx_byte_valid) && user_out_byte == $past(rx_byte))
    else $error("user byte not from the byte received before");
  chk_bad_drop: assert property ((rx_hdr_valid && !rx_ok) ##1
    rx_byte_valid |=> !user_out_valid)
    else $error("payload of a bad packet forwarded");
  chk_ack_hdr: assert property (ack_send |-> $past(rx_hdr_valid && rx_ok))
    else $error("ack sent without a good header");
  chk_link_rise: assert property ($rose(link_up) |->
    $past(rx_hdr_valid && rx_ok))
    else $error("link came up without a good header");

  cov_repeat: cover property (tx_valid && tx_repeat);
  cov_out: cover property (user_out_valid);
  cov_lost: cover property ($fell(link_up));
endmodule

bind hrl_link_ctrl hrl_link_props u_props (.pclk(pclk), .presetn(presetn),
  .tx_slot(tx_slot), .rx_hdr_valid(rx_hdr_valid), .rx_ok(rx_ok),
  .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
  .tx_repeat(tx_repeat), .tx_take(tx_take), .tx_hdr(tx_hdr),
  .user_out_valid(user_out_valid), .user_out_byte(user_out_byte),
  .ack_send(ack_send), .link_up(link_up));

`default_nettype wire

// ### tb/hrl_peer.sv
// peer master node and hop timer: frame and slot pulses, received packets
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
`default_nettype none

module hrl_peer
(
  input  wire logic            pclk,
  output logic                 frame_tick,
  output logic                 tx_slot,
  output logic                 rx_hdr_valid,
  output logic                 rx_ok,
  output hrl_pkg::hrl_hdr_type rx_hdr,
  output logic                 rx_byte_valid,
  output logic [7:0]           rx_byte
);
  initial
  begin
    frame_tick = 1'b0;
    tx_slot = 1'b0;
    rx_hdr_valid = 1'b0;
    rx_ok = 1'b0;
    rx_hdr = '0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
  end

  // one frame tick or one transmit slot
  task automatic pulse(input logic frame);
    @(posedge pclk);
    frame_tick <= frame;
    tx_slot <= !frame;
    @(posedge pclk);
    frame_tick <= 1'b0;
    tx_slot <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic send(input logic b, input logic [7:0] d,
                      input logic [3:0] s, input int n, input logic ok);
    hrl_pkg::hrl_hdr_type h;
    h = '0;
    h.broadcast = b;
    h.dest = d;
    h.src = 8'h01;
    h.hop_len = 8'h10;
    h.seq = s;
    h.ack_req = 1'b1;
    h.m_slot = 8'h40;
    h.s_slot = 8'h30;
    @(posedge pclk);
    rx_hdr_valid <= 1'b1;
    rx_ok <= ok;
    rx_hdr <= h;
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      rx_hdr_valid <= 1'b0;
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'hA0 + 8'(i);
    end
    @(posedge pclk);
    rx_hdr_valid <= 1'b0;
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_hdr <= ~h;
    repeat (3) @(posedge pclk);
  endtask
endmodule

`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the hop radio link controller
// assumes hrl_pkg compiled first and the peer model beside it
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]           paddr, user_out_byte, ack_dest, mse, sse;
  logic [31:0]          pwdata, prdata, rd;
  logic                 err, frame_tick, tx_slot, rx_hdr_valid, rx_ok;
  logic                 rx_byte_valid, tx_valid, tx_repeat, tx_take;
  logic                 user_out_valid, ack_send, link_up, ub, db;
  logic [7:0]           rx_byte;
  logic [15:0]          buf_count;
  logic [3:0]           s0;
  hrl_pkg::hrl_hdr_type rx_hdr, tx_hdr, last_hdr;
  int                   failures, comparisons, tx_cnt, rep_cnt, out_cnt;
  int                   ack_cnt, t0, o0, ub_n;
  // {pslverr, address, reset value}
  logic [40:0]          rows [13] = '{41'h0_00_00000000, 41'h0_04_00000001,
    41'h0_08_00000001, 41'h0_0C_00000000, 41'h0_10_0000FFFF,
    41'h0_14_00000010, 41'h0_18_00000001, 41'h0_1C_00000004,
    41'h0_20_00000000, 41'h0_24_00000008, 41'h0_28_00002020,
    41'h0_2C_000006C8, 41'h1_34_00000000};

  hrl_link_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_tick(frame_tick), .tx_slot(tx_slot), .buf_count(buf_count),
    .rx_hdr_valid(rx_hdr_valid), .rx_ok(rx_ok), .rx_hdr(rx_hdr),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
    .tx_repeat(tx_repeat), .tx_take(tx_take), .tx_hdr(tx_hdr),
    .user_out_valid(user_out_valid), .user_out_byte(user_out_byte),
    .ack_send(ack_send), .ack_dest(ack_dest), .link_up(link_up),
    .master_slot_eff(mse), .slave_slot_eff(sse), .user_baud_tick(ub),
    .diag_baud_tick(db));

  hrl_peer u_peer (.pclk(pclk), .frame_tick(frame_tick), .tx_slot(tx_slot),
    .rx_hdr_valid(rx_hdr_valid), .rx_ok(rx_ok), .rx_hdr(rx_hdr),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte));

  // ****************************************************************
  // clock, event counters, helpers
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    tx_cnt <= tx_cnt + (tx_valid === 1'b1);
    rep_cnt <= rep_cnt + (tx_valid === 1'b1 && tx_repeat === 1'b1);
    out_cnt <= out_cnt + (user_out_valid === 1'b1);
    ack_cnt <= ack_cnt + (ack_send === 1'b1);
    ub_n <= ub_n + ub;
    if (tx_valid === 1'b1)
      last_hdr <= tx_hdr;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic finish_test;
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    finish_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    buf_count = 16'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 13; i++)
    begin
      apb(1'b0, rows[i][39:32], 32'h0);
      check(rd, rows[i][31:0]);
      check(err, rows[i][40]);
    end
    apb(1'b1, 8'h34, 32'h5);
    check(err, 1'b1);
    apb(1'b1, 8'h00, 32'h7);
    apb(1'b1, 8'h00, 32'h8);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    // pair slave: broadcast does not lock
    u_peer.send(1'b1, 8'hFF, 4'h1, 2, 1'b1);
    check(link_up, 1'b0);
    check(mse, 8'h20);
    buf_count <= 16'h5;
    u_peer.pulse(1'b0);
    check(tx_cnt, 0);
    o0 = out_cnt;
    u_peer.send(1'b0, 8'h01, 4'h2, 3, 1'b1);
    check(link_up, 1'b1);
    check(out_cnt - o0, 3);
    check(mse, 8'h40);
    check(sse, 8'h30);
    check(ack_cnt, 1);
    check(ack_dest, 8'h01);
    // duplicate, bad and foreign packets
    o0 = out_cnt;
    u_peer.send(1'b0, 8'h01, 4'h2, 3, 1'b1);
    u_peer.send(1'b0, 8'h01, 4'h3, 2, 1'b0);
    u_peer.send(1'b0, 8'h02, 4'h3, 2, 1'b1);
    check(out_cnt - o0, 0);
    t0 = tx_cnt;
    u_peer.pulse(1'b0);
    check(tx_cnt - t0, 0);
    // launches, repeats forced off
    apb(1'b1, 8'h20, 32'h2);
    u_peer.send(1'b0, 8'h01, 4'h4, 0, 1'b1);
    t0 = tx_cnt;
    repeat (3) u_peer.pulse(1'b0);
    check(tx_cnt - t0, 3);
    check(rep_cnt, 0);
    check(last_hdr.broadcast, 1'b0);
    check(last_hdr.dest, 8'h01);
    // fill level and idle frame boundary
    buf_count <= 16'h0;
    u_peer.pulse(1'b0);
    apb(1'b1, 8'h18, 32'h8);
    buf_count <= 16'h5;
    t0 = tx_cnt;
    repeat (4) u_peer.pulse(1'b1);
    u_peer.pulse(1'b0);
    check(tx_cnt - t0, 0);
    u_peer.pulse(1'b1);
    u_peer.pulse(1'b0);
    check(tx_cnt - t0, 1);
    // missed frame limit
    apb(1'b1, 8'h2C, 32'h4);
    t0 = ub_n;
    u_peer.send(1'b0, 8'h01, 4'h5, 0, 1'b1);
    repeat (7) u_peer.pulse(1'b1);
    check(ub_n - t0, 10);
    check(link_up, 1'b1);
    u_peer.pulse(1'b1);
    check(link_up, 1'b0);
    // multi-drop master with two repeats
    apb(1'b1, 8'h00, 32'h3);
    buf_count <= 16'h1;
    t0 = tx_cnt;
    u_peer.pulse(1'b0);
    check(tx_cnt - t0, 1);
    check(last_hdr.broadcast, 1'b1);
    s0 = last_hdr.seq;
    repeat (2) u_peer.pulse(1'b0);
    check(rep_cnt, 2);
    check(last_hdr.seq, s0);
    u_peer.pulse(1'b0);
    check(last_hdr.seq == s0, 1'b0);
    check(tx_cnt - t0, 4);
    finish_test();
  end
endmodule

`default_nettype wire
